// *** src/plug_cs_pkg.sv ***
// Package: constants, field layout and carrier types for the plug chip-select control block.
// Assumes configuration space word offset 46h and 16-bit little-endian byte enables.
package plug_cs_pkg;

  // Register location and reset
  localparam logic [7:0] CTRL_OFFSET = 8'h46;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WRITABLE = 16'h1e0f;

  // Field positions
  localparam int SEL_A_IO_BIT = 0;
  localparam int SEL_A_MEM_BIT = 1;
  localparam int SEL_B_IO_BIT = 2;
  localparam int SEL_B_MEM_BIT = 3;
  localparam int IRQ12_FN_LSB = 9;
  localparam int SEL_A_UBM_BIT = 11;
  localparam int SEL_B_UBM_BIT = 12;

  // Masked upper IO address bits
  localparam int UPPER_MASK_LSB = 8;
  localparam int UPPER_MASK_MSB = 10;

  // Pin function of the interrupt 12 pin
  typedef enum logic [1:0] {
    IRQ12_AS_INTERRUPT = 2'b00,
    IRQ12_AS_NONE = 2'b01,
    IRQ12_AS_SMB_ALERT = 2'b10,
    IRQ12_AS_USB_OC = 2'b11
  } irq12_fn_t;

  // Configuration access toward the register
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] offset;
    logic [1:0] byte_en;
    logic [15:0] wdata;
  } cfg_req_t;

  // Bus cycle seen by the decoder
  typedef struct packed {
    logic active;
    logic is_io;
    logic is_mem;
    logic [31:0] addr;
  } bus_cycle_t;

  // Range monitor hit and near-hit flags
  typedef struct packed {
    logic io3_hit;
    logic io3_upper_only;
    logic io4_hit;
    logic io4_upper_only;
    logic mem1_hit;
    logic mem2_hit;
  } range_hits_t;

endpackage

// *** src/plug_cs_select.sv ***
// One chip-select decoder: IO and memory enables, upper mask, pin gating.
// Assumes range hits and cycle qualifiers are on the same clock as the decoder.
`timescale 1ns/1ps
`default_nettype none
module plug_cs_select (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic clk_en, // Clock enable, freezes state when low
  input wire logic pin_is_select, // Pin-function field picks chip select
  input wire logic io_enable, // IO decode enable
  input wire logic memory_enable, // Memory decode enable
  input wire logic upper_mask, // Drop IO address bits 10:8 from decode
  input wire logic cycle_active, // Decoded cycle in progress
  input wire logic cycle_io, // Cycle is IO
  input wire logic cycle_mem, // Cycle is memory
  input wire logic io_hit, // Full IO range hit
  input wire logic io_upper_only, // IO hit except on bits 10:8
  input wire logic mem_hit, // Memory range hit
  output logic claim, // Claim and forward to ISA
  output logic select_n // Chip select pin, active low
);

  logic next_select_n;
  logic io_match;

  // Upper mask widens the IO match; otherwise only the low eight bits may be masked
  always_comb begin
    io_match = io_hit || (upper_mask && io_upper_only);
  end

  // Claim follows enables gated by pin function
  always_comb begin
    claim = pin_is_select && cycle_active &&
            ((io_enable && cycle_io && io_match) ||
             (memory_enable && cycle_mem && mem_hit));
    next_select_n = ~claim;
  end

  // Select pin registered from claim: low on the clock after each claiming cycle with clk_en high
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      select_n <= 1'b1;
    end else if (clk_en) begin
      select_n <= next_select_n;
    end
  end

endmodule
`default_nettype wire

// *** src/plug_chip_select_decode.sv ***
// Control register and decode for two chip-select pins and the interrupt 12 pin function.
// Assumes config accesses and bus cycles arrive on clk_sys; the raw interrupt 12 pin is synchronised here.
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: IO enable A routes range-3 IO hits to chip select A, claimed to ISA.
// R2: Memory enable A routes range-1 memory hits to chip select A, claimed.
// R3: IO enable B routes range-4 IO hits to chip select B, claimed to ISA.
// R4: Memory enable B routes range-2 memory hits to chip select B, claimed.
// R5: Select A enables do nothing unless pin function selects chip select A.
// R6: Select B enables do nothing unless pin function selects chip select B.
// R7: Pin function 00 passes the pin as interrupt request 12.
// R8: Pin function 01 ignores pin; other interrupt 12 sources still drive it.
// R9: Function 10 feeds SMBus alert, 11 feeds USB over-current one.
// R10: Upper mask A set drops IO address bits 10:8 from select A.
// R11: Upper mask A clear limits select A masking to low eight bits.
// R12: Upper mask B set drops IO address bits 10:8 from select B.
// R13: Upper mask B clear limits select B masking to low eight bits.
// R14: Sixteen-bit control register resets to zero, read-write from config.
// R15: Chip selects are active low and held through the qualified cycle; the code registers them, so they go low on the clock after the claim.
module plug_chip_select_decode (
  input wire logic clk_sys, // System clock, 100 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic clk_en, // Clock enable, freezes state when low
  input wire plug_cs_pkg::cfg_req_t cfg_req, // Config read or write
  output logic [15:0] cfg_rdata, // Config read data, registered
  output logic cfg_hit, // Config access targets this register
  input wire plug_cs_pkg::bus_cycle_t bus_cycle, // Current bus cycle
  input wire plug_cs_pkg::range_hits_t range_hits, // Range monitor results
  input wire logic pin_function_select_f6, // Pin A set to chip select
  input wire logic pin_function_select_f7, // Pin B set to chip select
  input wire logic irq12_pin, // Raw interrupt 12 pin
  input wire logic mouse_interrupt, // Internal mouse interrupt
  input wire logic keyboard_ctrl_interrupt12, // Keyboard controller source
  input wire logic serial_interrupt12, // Serial interrupt frame 12
  output logic interrupt12_to_pic, // Interrupt request 12 to controller
  output logic smbus_alert_n, // SMBus alert to management logic
  output logic usb_overcurrent_one_n, // Over-current one to USB
  output logic isa_claim, // Claim the access and forward to ISA
  output logic plug_chip_select_a_n, // Chip select A pin
  output logic plug_chip_select_b_n // Chip select B pin
);

  logic [15:0] plug_chip_select_control;
  logic [15:0] next_plug_chip_select_control;
  logic [15:0] next_cfg_rdata;
  logic [15:0] lane_mask;
  logic pin_meta;
  logic pin_sync;
  logic [1:0] fn_code;
  plug_cs_pkg::irq12_fn_t interrupt12_pin_function;
  logic claim_a;
  logic claim_b;
  logic next_interrupt12;
  logic next_smb;
  logic next_usb;

  assign cfg_hit = (cfg_req.offset == plug_cs_pkg::CTRL_OFFSET);
  assign lane_mask = {{8{cfg_req.byte_en[1]}}, {8{cfg_req.byte_en[0]}}};

  // Register write path with byte enables; reserved bits stay zero
  always_comb begin
    next_plug_chip_select_control = plug_chip_select_control;
    next_cfg_rdata = cfg_rdata;
    if (cfg_req.write && cfg_hit) begin
      next_plug_chip_select_control = (plug_chip_select_control & ~lane_mask) |
        (cfg_req.wdata & lane_mask & plug_cs_pkg::CTRL_WRITABLE); // [R14]
    end
    if (cfg_req.read) begin
      next_cfg_rdata = cfg_hit ? plug_chip_select_control : 16'h0000;
    end
  end

  // Register storage and read data
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      plug_chip_select_control <= plug_cs_pkg::CTRL_RESET; // [R14]
      cfg_rdata <= 16'h0000;
    end else if (clk_en) begin
      plug_chip_select_control <= next_plug_chip_select_control;
      cfg_rdata <= next_cfg_rdata;
    end
  end

  // Chip select A: range 3 IO, range 1 memory
  plug_cs_select u_sel_a (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .pin_is_select(pin_function_select_f6), // [R5]
    .io_enable(plug_chip_select_control[plug_cs_pkg::SEL_A_IO_BIT]), // [R1]
    .memory_enable(plug_chip_select_control[plug_cs_pkg::SEL_A_MEM_BIT]), // [R2]
    .upper_mask(plug_chip_select_control[plug_cs_pkg::SEL_A_UBM_BIT]), // [R10] [R11]
    .cycle_active(bus_cycle.active),
    .cycle_io(bus_cycle.is_io),
    .cycle_mem(bus_cycle.is_mem),
    .io_hit(range_hits.io3_hit),
    .io_upper_only(range_hits.io3_upper_only),
    .mem_hit(range_hits.mem1_hit),
    .claim(claim_a),
    .select_n(plug_chip_select_a_n) // [R15]
  );

  // Chip select B: range 4 IO, range 2 memory
  plug_cs_select u_sel_b (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .pin_is_select(pin_function_select_f7), // [R6]
    .io_enable(plug_chip_select_control[plug_cs_pkg::SEL_B_IO_BIT]), // [R3]
    .memory_enable(plug_chip_select_control[plug_cs_pkg::SEL_B_MEM_BIT]), // [R4]
    .upper_mask(plug_chip_select_control[plug_cs_pkg::SEL_B_UBM_BIT]), // [R12] [R13]
    .cycle_active(bus_cycle.active),
    .cycle_io(bus_cycle.is_io),
    .cycle_mem(bus_cycle.is_mem),
    .io_hit(range_hits.io4_hit),
    .io_upper_only(range_hits.io4_upper_only),
    .mem_hit(range_hits.mem2_hit),
    .claim(claim_b),
    .select_n(plug_chip_select_b_n) // [R15]
  );

  // Either select claims the access for ISA forwarding
  assign isa_claim = claim_a | claim_b; // [R1] [R2] [R3] [R4]

  // Two-stage synchroniser for the raw pin
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else if (clk_en) begin
      pin_meta <= irq12_pin;
      pin_sync <= pin_meta;
    end
  end

  assign fn_code = plug_chip_select_control[plug_cs_pkg::IRQ12_FN_LSB +: 2];
  assign interrupt12_pin_function = plug_cs_pkg::irq12_fn_t'(fn_code);

  // Pin function steering
  always_comb begin
    next_interrupt12 = mouse_interrupt | keyboard_ctrl_interrupt12 | serial_interrupt12; // [R8]
    next_smb = 1'b1;
    next_usb = 1'b1;
    unique case (interrupt12_pin_function)
      plug_cs_pkg::IRQ12_AS_INTERRUPT: begin
        next_interrupt12 = next_interrupt12 | pin_sync; // [R7]
      end
      plug_cs_pkg::IRQ12_AS_NONE: begin
        next_interrupt12 = next_interrupt12; // [R8]
      end
      plug_cs_pkg::IRQ12_AS_SMB_ALERT: begin
        next_smb = pin_sync; // [R9]
      end
      plug_cs_pkg::IRQ12_AS_USB_OC: begin
        next_usb = pin_sync; // [R9]
      end
    endcase
  end

  // Registered pin-function outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      interrupt12_to_pic <= 1'b0;
      smbus_alert_n <= 1'b1;
      usb_overcurrent_one_n <= 1'b1;
    end else if (clk_en) begin
      interrupt12_to_pic <= next_interrupt12;
      smbus_alert_n <= next_smb;
      usb_overcurrent_one_n <= next_usb;
    end
  end

endmodule
`default_nettype wire

// *** sim/plug_cs_isa_peripheral.sv ***
// ISA peripheral model: counts the cycles in which each chip select is low.
// Assumes the selects are sampled on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module plug_cs_isa_peripheral (
  input wire logic clk_sys, // Clock
  input wire logic reset, // Reset
  input wire logic select_a_n, // Chip select A
  input wire logic select_b_n, // Chip select B
  output var int low_a, // Cycles with A low
  output var int low_b // Cycles with B low
);
  // Counts a cycle only while its select is held low
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      low_a <= 0;
      low_b <= 0;
    end else begin
      low_a <= low_a + int'(!select_a_n);
      low_b <= low_b + int'(!select_b_n);
    end
  end
endmodule
`default_nettype wire

// *** sim/plug_cs_decode_props.sv ***
// Checker: port relations of the chip-select decode block.
// Assumes one clock domain and a bind to plug_chip_select_decode.
`timescale 1ns/1ps
`default_nettype none
module plug_cs_decode_props (
  input wire logic clk_sys, // Clock
  input wire logic reset, // Reset
  input wire logic clk_en, // Enable
  input wire plug_cs_pkg::cfg_req_t cfg_req, // Request
  input wire logic [15:0] cfg_rdata, // Read data
  input wire logic cfg_hit, // Offset match
  input wire plug_cs_pkg::bus_cycle_t bus_cycle, // Bus cycle
  input wire plug_cs_pkg::range_hits_t range_hits, // Hits
  input wire logic pin_function_select_f6, // Pin A mode
  input wire logic pin_function_select_f7, // Pin B mode
  input wire logic mouse_interrupt, // Mouse
  input wire logic interrupt12_to_pic, // Interrupt out
  input wire logic isa_claim, // Claim
  input wire logic plug_chip_select_a_n, // Select A
  input wire logic plug_chip_select_b_n // Select B
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Decode, register and interrupt relations
  AST_CLAIM_SELECT: assert property (
    clk_en && isa_claim |=> !(plug_chip_select_a_n && plug_chip_select_b_n))
    else $error("claim gave no select");
  AST_SELECT_RELEASE: assert property (
    clk_en && !isa_claim |=> plug_chip_select_a_n && plug_chip_select_b_n)
    else $error("select held without claim");
  AST_IDLE_NO_CLAIM: assert property (
    !bus_cycle.active |-> !isa_claim) else $error("claim with no cycle");
  AST_PIN_GATE: assert property (
    !pin_function_select_f6 && !pin_function_select_f7 |-> !isa_claim)
    else $error("claim with pins not selects");
  AST_NO_HIT: assert property (
    range_hits == '0 |-> !isa_claim) else $error("claim without hit");
  AST_RESET_VALUE: assert property (
    $fell(reset) |-> cfg_rdata == 16'h0000 && plug_chip_select_a_n && plug_chip_select_b_n)
    else $error("bad value after reset");
  AST_CFG_HIT: assert property (
    cfg_hit == (cfg_req.offset == plug_cs_pkg::CTRL_OFFSET)) else $error("bad offset match");
  AST_RESERVED_ZERO: assert property (
    (cfg_rdata & ~plug_cs_pkg::CTRL_WRITABLE) == 16'h0000) else $error("reserved bit set");
  AST_WRITE_READ: assert property (
    clk_en && cfg_req.write && cfg_hit && cfg_req.byte_en == 2'b11
    ##1 clk_en && !cfg_req.write
    ##1 clk_en && cfg_req.read && !cfg_req.write && cfg_hit
    |=> cfg_rdata == ($past(cfg_req.wdata, 3) & plug_cs_pkg::CTRL_WRITABLE))
    else $error("read did not return written value");
  AST_MISS_READ: assert property (
    clk_en && cfg_req.read && !cfg_hit |=> cfg_rdata == 16'h0000) else $error("miss read");
  AST_MOUSE_IRQ: assert property (
    clk_en && mouse_interrupt |=> interrupt12_to_pic) else $error("mouse lost");
  // Main scenarios reached
  cover property (isa_claim);
  cover property (!plug_chip_select_b_n);
  cover property (cfg_req.write && cfg_hit);
  cover property (!clk_en && cfg_req.write && cfg_hit);
endmodule
bind plug_chip_select_decode plug_cs_decode_props u_plug_cs_decode_props (.*);
`default_nettype wire

// *** sim/plug_chip_select_decode_tb_top.sv ***
// Testbench: register, decode and pin-function checks against a bench model.
// Assumes the package constants; clk_en and all interrupt sources are driven.
`timescale 1ns/1ps
`default_nettype none
module plug_chip_select_decode_tb_top;
  logic clk_sys = 0, reset = 1, f6 = 0, f7 = 0, pin = 1, en = 1;
  logic [2:0] src = '0;
  plug_cs_pkg::cfg_req_t req = '0;
  plug_cs_pkg::bus_cycle_t cyc = '0;
  plug_cs_pkg::range_hits_t hits = '0;
  logic [15:0] rdata, model = 0;
  logic hit, irq, smb, usb, claim, sa, sb;
  logic [1:0] e;
  int mismatches = 0, tests_run = 0, low_a = 0, low_b = 0, seen_a, seen_b;
  plug_chip_select_decode u_plug_chip_select_decode (.clk_sys(clk_sys), .reset(reset),
    .clk_en(en), .cfg_req(req), .cfg_rdata(rdata), .cfg_hit(hit), .bus_cycle(cyc),
    .range_hits(hits), .pin_function_select_f6(f6), .pin_function_select_f7(f7),
    .irq12_pin(pin), .mouse_interrupt(src[0]), .keyboard_ctrl_interrupt12(src[1]),
    .serial_interrupt12(src[2]), .interrupt12_to_pic(irq), .smbus_alert_n(smb),
    .usb_overcurrent_one_n(usb), .isa_claim(claim), .plug_chip_select_a_n(sa),
    .plug_chip_select_b_n(sb));
  plug_cs_isa_peripheral u_plug_cs_isa_peripheral (.clk_sys(clk_sys), .reset(reset),
    .select_a_n(sa), .select_b_n(sb), .low_a(seen_a), .low_b(seen_b));
  // Clock and watchdog
  initial forever #5 clk_sys = ~clk_sys;
  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One config pulse; the model follows writable bits of enabled lanes
  task automatic cfg(input logic wr, input logic [7:0] off, input logic [1:0] be,
                     input logic [15:0] d);
    logic [15:0] lanes;
    lanes = {{8{be[1]}}, {8{be[0]}}} & plug_cs_pkg::CTRL_WRITABLE;
    @(posedge clk_sys);
    req <= {wr, !wr, off, be, d};
    #1;
    check(hit, off == plug_cs_pkg::CTRL_OFFSET);
    @(posedge clk_sys);
    req <= '0;
    #1;
    if (wr && en && off == plug_cs_pkg::CTRL_OFFSET) model = (model & ~lanes) | (d & lanes);
    if (!wr) check(rdata, off == plug_cs_pkg::CTRL_OFFSET ? model : 16'h0000);
  endtask
  // Expected select per pin from the enables, masks and hits
  function automatic logic [1:0] want();
    logic io, mem;
    io = cyc.active && cyc.is_io;
    mem = cyc.active && cyc.is_mem;
    want[0] = f6 && (io && model[0] && (hits.io3_hit || model[11] && hits.io3_upper_only)
      || mem && model[1] && hits.mem1_hit);
    want[1] = f7 && (io && model[2] && (hits.io4_hit || model[12] && hits.io4_upper_only)
      || mem && model[3] && hits.mem2_hit);
  endfunction
  initial begin
    void'($urandom(32'h4678));
    repeat (2) @(posedge clk_sys);
    reset <= 0;
    cfg(0, plug_cs_pkg::CTRL_OFFSET, 2'b11, 16'h0000);
    // Lane writes, reserved bits and an unmapped offset
    for (int i = 0; i < 20; i++) begin
      cfg(1, i % 5 ? plug_cs_pkg::CTRL_OFFSET : 8'h44, 2'($urandom), 16'($urandom));
      cfg(0, i % 3 ? plug_cs_pkg::CTRL_OFFSET : 8'h44, 2'b11, 16'h0000);
    end
    // Random decode traffic
    for (int i = 0; i < 400; i++) begin
      if (i % 8 == 0) cfg(1, plug_cs_pkg::CTRL_OFFSET, 2'b11, 16'($urandom));
      @(posedge clk_sys);
      f6 <= 1'($urandom);
      f7 <= 1'($urandom);
      cyc <= {3'($urandom), 32'h0};
      hits <= 6'($urandom);
      #1;
      e = want();
      check(claim, e[0] | e[1]);
      low_a += e[0];
      low_b += e[1];
      @(posedge clk_sys);
      cyc <= '0;
      #1;
      check({sb, sa}, {~e[1], ~e[0]});
    end
    repeat (2) @(posedge clk_sys);
    #1;
    check(16'(seen_a), 16'(low_a));
    check(16'(seen_b), 16'(low_b));
    // Each pin function with the pin low and high, then one other interrupt source
    for (int m = 0; m < 8; m++) begin
      cfg(1, plug_cs_pkg::CTRL_OFFSET, 2'b10, 16'(m[1:0]) << 9);
      @(posedge clk_sys);
      pin <= m[2];
      repeat (4) @(posedge clk_sys);
      #1;
      check({irq, smb, usb}, {m[1:0] == 0 && m[2], m[1:0] != 2 || m[2], m[1:0] != 3 || m[2]});
      @(posedge clk_sys);
      src <= 3'b001 << (m % 3);
      repeat (2) @(posedge clk_sys);
      #1;
      check(irq, 1);
      @(posedge clk_sys);
      src <= 3'b000;
    end
    // Clock enable low: a hit write must not land
    @(posedge clk_sys);
    en <= 0;
    cfg(1, plug_cs_pkg::CTRL_OFFSET, 2'b11, ~model);
    @(posedge clk_sys);
    en <= 1;
    cfg(0, plug_cs_pkg::CTRL_OFFSET, 2'b11, 16'h0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
